/* File: logic/serial_port_pkg.sv */
// shared constants for the radio serial data port
package serial_port_pkg;
  localparam logic [1:0] FMT_NORMAL = 2'h0; // fifo / packet mode
  localparam logic [1:0] FMT_SYNC = 2'h1; // synchronous serial
  localparam logic [1:0] FMT_RANDOM = 2'h2; // unused format code
  localparam logic [1:0] FMT_ASYNC = 2'h3; // asynchronous serial
  localparam int OVERSAMPLE = 8; // samples per asynchronous bit
  localparam int CLK_MHZ = 100; // ref_clk rate
  localparam int CAL_FULL_US = 720; // full calibration time
  localparam int CAL_VCO_US = 150; // calibration without charge pump
  localparam int SETTLE_US = 90; // turn-on with stored values
  localparam int CAL_FULL_CYC = CAL_FULL_US * CLK_MHZ;
  localparam int CAL_VCO_CYC = CAL_VCO_US * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam logic [5:0] SEL_SERIAL_DATA = 6'h0D; // pin select: serial rx data
  localparam logic [5:0] SEL_SERIAL_CLK = 6'h0B; // pin select: serial bit clock
  localparam logic [5:0] SEL_TX_OE_N = 6'h2D; // pin select: pin0 input indicator
  localparam logic [5:0] SEL_LOW = 6'h2F; // pin select: constant low
  localparam int CP_CAL_LSB = 4; // charge pump cal field in cal word 3
  localparam int CP_CAL_MSB = 5;
  localparam logic [31:0] PRE_SYNC = 32'hAAAAD391; // preamble + sync pattern
  localparam int PRE_SYNC_BITS = 32;
  localparam logic [7:0] CAL3_RESET = 8'hA9; // synth cal word 3 after reset
  localparam logic [15:0] RATE_RESET = 16'h00F9; // oversample divider after reset
  localparam logic [7:0] ADDR_CFG = 8'h00; // control register
  localparam logic [7:0] ADDR_PINSEL = 8'h01; // pin select fields
  localparam logic [7:0] ADDR_CAL3 = 8'h02; // synth cal word 3
  localparam logic [7:0] ADDR_CMD = 8'h03; // command strobes
  localparam logic [7:0] ADDR_STAT = 8'h04; // status
  localparam logic [7:0] ADDR_RATE = 8'h05; // oversample tick divider
endpackage : serial_port_pkg

/* File: logic/serial_shift_unit.sv */
// bit timing: oversample tick and bit period tick generators
`timescale 1ns/1ps
module serial_shift_unit #(
  parameter int DIV_W = 16
) (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic clkEn, // freezes state when low
  input wire logic active, // transmit or receive running
  input wire logic [DIV_W-1:0] sampleDiv, // cycles per oversample tick, minus one
  output logic sampleTick, // one oversample tick
  output logic bitTick // one bit period elapsed
);
  logic [DIV_W-1:0] divCnt_q;
  logic [2:0] phase_q;

  // oversample tick generator, eight ticks per bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt_q <= '0;
      sampleTick <= 1'b0;
    end else if (clkEn) begin
      sampleTick <= 1'b0;
      if (!active) begin
        divCnt_q <= '0;
      end else if (divCnt_q >= sampleDiv) begin
        divCnt_q <= '0;
        sampleTick <= 1'b1; // R5
      end else begin
        divCnt_q <= divCnt_q + 1'b1;
      end
    end
  end

  // bit phase counter across the eight ticks
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= '0;
      bitTick <= 1'b0;
    end else if (clkEn) begin
      bitTick <= 1'b0;
      if (!active) begin
        phase_q <= '0;
      end else if (sampleTick) begin
        phase_q <= phase_q + 1'b1;
        bitTick <= (phase_q == 3'(serial_port_pkg::OVERSAMPLE - 1)); // R5
      end
    end
  end

  samples_per_bit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    bitTick |-> $past(phase_q) == 3'h7) else $error("bit tick off phase"); // R5
endmodule : serial_shift_unit

/* File: logic/radio_serial_data_port.sv */
// raw serial data port: async and sync serial modes plus synth calibration timing
//
// Summary of operation
// R1 - format value 3 selects asynchronous serial
// R2 - async mode bypasses packet, fifo, coding
// R3 - host avoids MSK with asynchronous mode
// R4 - pin 0 tx input; selected pin rx
// R5 - tx input oversampled eight times per bit
// R6 - host bit period error under one eighth
// R7 - format value 1 selects synchronous serial
// R8 - device drives the synchronous bit clock
// R9 - pin 0 becomes input during transmit
// R10 - sync mode field enables preamble/sync handling
// R11 - packet features usable, address filter unavailable
// R12 - device inserts/strips preamble and sync word
// R13 - full calibration about 720 us
// R14 - host may restore stored calibration words
// R15 - host may reuse current calibration results
// R16 - zero charge pump field: vco-only calibration
// R17 - host rewrites test registers after sleep
// R18 - rx/tx strobes calibrate first from idle
// R19 - host holds data around device sampling edge
`timescale 1ns/1ps
module radio_serial_data_port #(
  parameter int CAL_FULL_CYCLES = serial_port_pkg::CAL_FULL_CYC, // full calibration
  parameter int CAL_VCO_CYCLES = serial_port_pkg::CAL_VCO_CYC, // vco-only calibration
  parameter int SETTLE_CYCLES = serial_port_pkg::SETTLE_CYC // turn-on settle
) (
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic clkEn, // clock enable
  input wire logic [7:0] regAddr, // register address
  input wire logic [7:0] regWdata, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdata, // read data, cycle after strobe
  input wire logic pin0In, // general_pin_0 input level
  input wire logic pin1In, // general_pin_1 input level
  input wire logic pin2In, // general_pin_2 input level
  output logic [2:0] pinOut, // general pin output levels
  output logic [2:0] pinOe, // general pin output enables
  input wire logic rxBit, // demodulated receive bit
  input wire logic rxBitValid, // receive bit strobe from demodulator
  output logic txBit, // bit to modulator
  output logic txBitValid, // modulator bit strobe
  output logic synthOn, // synthesizer running
  output logic calBusy // calibration in progress
);
  typedef enum logic [2:0] {IDLE, CAL, SETTLE, RX, TX} state_t;
  state_t state_q;

  logic [1:0] fmt_q; // packet_format_select
  logic syncMode_q; // sync_word_mode: preamble/sync handling on
  logic autoCal_q; // auto_calibration_select
  logic [5:0] selPin0_q, selPin1_q, selPin2_q;
  logic [7:0] cal3_q; // synth_cal_word_3
  logic [15:0] sampleDiv_q;
  logic [2:0] pinSync1_q, pinSync2_q;
  logic [16:0] calCnt_q;
  logic [5:0] hdrCnt_q;
  logic [31:0] hunt_q;
  logic locked_q;
  logic sampleTick, bitTick;
  logic asyncMode, syncSerial, active, txActive, rxSerial, txSerial;
  logic bitClk_q, rxData_q, txPend_q;
  logic [2:0] ones_q;
  logic [7:0] rdData;
  logic [2:0] pinOutD, pinOeD;

  assign asyncMode = (fmt_q == serial_port_pkg::FMT_ASYNC); // R1 R2
  assign syncSerial = (fmt_q == serial_port_pkg::FMT_SYNC); // R7
  assign txActive = (state_q == TX);
  assign active = (state_q == RX) || txActive;
  assign txSerial = txActive && (asyncMode || syncSerial);
  assign rxSerial = (state_q == RX) && (asyncMode || syncSerial);

  // two-flop synchronisers for the pin inputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
    end else if (clkEn) begin
      pinSync1_q <= {pin2In, pin1In, pin0In};
      pinSync2_q <= pinSync1_q;
    end
  end

  serial_shift_unit #(.DIV_W(16)) shifter (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .active(active),
    .sampleDiv(sampleDiv_q),
    .sampleTick(sampleTick),
    .bitTick(bitTick)
  );

  // configuration registers written by software
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_q <= serial_port_pkg::FMT_NORMAL;
      syncMode_q <= 1'b1;
      autoCal_q <= 1'b1;
      selPin0_q <= serial_port_pkg::SEL_LOW;
      selPin1_q <= serial_port_pkg::SEL_LOW;
      selPin2_q <= serial_port_pkg::SEL_LOW;
      cal3_q <= serial_port_pkg::CAL3_RESET;
      sampleDiv_q <= serial_port_pkg::RATE_RESET;
    end else if (clkEn && regWr) begin
      unique case (regAddr)
        serial_port_pkg::ADDR_CFG: begin
          fmt_q <= regWdata[1:0];
          syncMode_q <= regWdata[2]; // R10
          autoCal_q <= regWdata[3];
        end
        serial_port_pkg::ADDR_PINSEL: begin
          unique case (regWdata[7:6])
            2'h0: selPin0_q <= regWdata[5:0];
            2'h1: selPin1_q <= regWdata[5:0];
            2'h2: selPin2_q <= regWdata[5:0];
            default: ;
          endcase
        end
        serial_port_pkg::ADDR_CAL3: cal3_q <= regWdata; // R14 R16
        serial_port_pkg::ADDR_RATE: sampleDiv_q <= {8'h00, regWdata};
        default: ;
      endcase
    end
  end

  // radio state machine with calibration before rx/tx from idle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= IDLE;
      calCnt_q <= '0;
      txPend_q <= 1'b0;
    end else if (clkEn) begin
      unique case (state_q)
        IDLE: begin
          if (regWr && regAddr == serial_port_pkg::ADDR_CMD && regWdata[1:0] != 2'h0) begin
            txPend_q <= regWdata[1];
            if (autoCal_q) begin
              state_q <= CAL; // R18
              calCnt_q <= (cal3_q[serial_port_pkg::CP_CAL_MSB:serial_port_pkg::CP_CAL_LSB]
                == 2'h0) ? 17'(CAL_VCO_CYCLES - 1) : 17'(CAL_FULL_CYCLES - 1); // R13 R16
            end else begin
              state_q <= SETTLE; // R14
              calCnt_q <= 17'(SETTLE_CYCLES - 1);
            end
          end
        end
        CAL, SETTLE: begin
          if (calCnt_q == '0) begin
            state_q <= txPend_q ? TX : RX;
          end else begin
            calCnt_q <= calCnt_q - 1'b1;
          end
        end
        RX, TX: begin
          if (regWr && regAddr == serial_port_pkg::ADDR_CMD && regWdata[2]) begin
            state_q <= IDLE;
          end
        end
      endcase
    end
  end

  // sync mode bit clock: high for the second half of each bit
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitClk_q <= 1'b0;
    end else if (clkEn) begin
      if (!(syncSerial && active)) begin
        bitClk_q <= 1'b0;
      end else if (bitTick) begin
        bitClk_q <= 1'b0; // R8
      end else if (sampleTick && ones_q == 3'h3) begin
        bitClk_q <= 1'b1; // R8
      end
    end
  end

  // tx path: async pass-through of every sample, sync sampling on clock rise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_q <= '0;
      txBit <= 1'b0;
      txBitValid <= 1'b0;
      hdrCnt_q <= '0;
    end else if (clkEn) begin
      txBitValid <= 1'b0;
      if (!active) begin
        ones_q <= '0;
        hdrCnt_q <= '0;
      end else if (sampleTick) begin
        ones_q <= ones_q + 1'b1;
      end
      if (txSerial && syncSerial && syncMode_q
          && hdrCnt_q < 6'(serial_port_pkg::PRE_SYNC_BITS) && bitTick) begin
        txBit <= serial_port_pkg::PRE_SYNC[5'(31 - hdrCnt_q)]; // R12
        txBitValid <= 1'b1;
        hdrCnt_q <= hdrCnt_q + 1'b1;
      end else if (txSerial && asyncMode && sampleTick) begin
        txBit <= pinSync2_q[0]; // R4 R5
        txBitValid <= 1'b1;
      end else if (txSerial && syncSerial && sampleTick && ones_q == 3'h3
          && (!syncMode_q || hdrCnt_q == 6'(serial_port_pkg::PRE_SYNC_BITS))) begin
        // payload samples once the device has sent its own header, or at once with sync_word_mode off
        txBit <= pinSync2_q[0]; // R8 R9
        txBitValid <= 1'b1;
      end
    end
  end

  // rx path: sync word hunt when enabled, then payload to the pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hunt_q <= '0;
      locked_q <= 1'b0;
      rxData_q <= 1'b0;
    end else if (clkEn) begin
      if (!rxSerial) begin
        locked_q <= 1'b0;
        hunt_q <= '0;
      end else if (rxBitValid) begin
        hunt_q <= {hunt_q[30:0], rxBit};
        if (asyncMode || !syncMode_q || locked_q) begin
          rxData_q <= rxBit; // R2 R10 R11 R12
        end else if ({hunt_q[30:0], rxBit} == serial_port_pkg::PRE_SYNC) begin
          locked_q <= 1'b1; // R12
        end
      end
    end
  end

  // pin output mux per selected signal
  always_comb begin
    pinOutD = '0;
    pinOeD = '1;
    for (int i = 0; i < 3; i++) begin
      logic [5:0] sel;
      sel = (i == 0) ? selPin0_q : (i == 1) ? selPin1_q : selPin2_q;
      unique case (sel)
        serial_port_pkg::SEL_SERIAL_DATA: pinOutD[i] = rxData_q; // R4 R9
        serial_port_pkg::SEL_SERIAL_CLK: pinOutD[i] = bitClk_q; // R8
        serial_port_pkg::SEL_TX_OE_N: pinOutD[i] = !txSerial;
        default: pinOutD[i] = 1'b0;
      endcase
    end
    if (txSerial) begin
      pinOeD[0] = 1'b0; // R4 R9
    end
  end

  // registered pin outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut <= '0;
      pinOe <= 3'h7;
      synthOn <= 1'b0;
      calBusy <= 1'b0;
    end else if (clkEn) begin
      pinOut <= pinOutD;
      pinOe <= pinOeD;
      synthOn <= (state_q != IDLE);
      calBusy <= (state_q == CAL);
    end
  end

  // register read mux
  always_comb begin
    unique case (regAddr)
      serial_port_pkg::ADDR_CFG: rdData = {4'h0, autoCal_q, syncMode_q, fmt_q};
      serial_port_pkg::ADDR_CAL3: rdData = cal3_q;
      serial_port_pkg::ADDR_STAT: rdData = {3'h0, locked_q, 1'b0, 3'(state_q)};
      serial_port_pkg::ADDR_RATE: rdData = sampleDiv_q[7:0];
      default: rdData = 8'h00;
    endcase
  end

  // read data one cycle after strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= regRd ? rdData : 8'h00;
    end
  end

  pin0_input_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clkEn && $past(clkEn) && $past(txSerial) |-> !pinOe[0]) else $error("pin0 driven in tx"); // R9
  cal_from_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_q == IDLE && $past(state_q) == IDLE && clkEn && regWr && regAddr ==
    serial_port_pkg::ADDR_CMD && regWdata[1:0] != 2'h0 && autoCal_q |=> state_q == CAL)
    else $error("no calibration on strobe"); // R18
  async_sample_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clkEn && txSerial && asyncMode && sampleTick |=> txBitValid)
    else $error("async sample missed"); // R5
  sync_clk_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(clkEn) && $past(!(syncSerial && active)) |-> !bitClk_q)
    else $error("bit clock runs outside sync transfer"); // R8
  no_hdr_async_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    asyncMode |-> hdrCnt_q == '0 || $past(!asyncMode)) else $error("header in async"); // R2
endmodule : radio_serial_data_port

/* File: dv/host_serial_model.sv */
// host-side model driving the raw serial transmit stream toward general_pin_0
`timescale 1ns/1ps
module host_serial_model (
  input wire logic linkClk, // host bit-timing clock, 125 ns
  input wire logic syncMode, // pace from the device bit clock instead
  input wire logic bitClk, // device bit clock seen on a general pin
  output logic txData // serial transmit level toward pin 0
);
  int cnt = 0;

  initial txData = 1'b0;

  // async: new level every 16 link clocks, exactly one programmed bit, no drift
  always @(posedge linkClk) begin
    if (!syncMode) begin
      cnt = (cnt == 15) ? 0 : cnt + 1;
      if (cnt == 0) txData <= 1'($urandom);
    end
  end

  // sync: change on the falling clock, well away from the sampling rise
  always @(negedge bitClk) begin
    if (syncMode) txData <= 1'($urandom);
  end
endmodule : host_serial_model

/* File: dv/radio_serial_data_port_tb.sv */
// self-checking bench for the radio serial data port
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module radio_serial_data_port_tb;
  localparam logic [7:0] CAL3_RST = 8'hA9;
  logic ref_clk = 1'b1;
  logic linkClk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic pin0In, pin1In, pin2In;
  logic [2:0] pinOut, pinOe;
  logic rxBit = 1'b0;
  logic rxBitValid = 1'b0;
  logic txBit, txBitValid, synthOn, calBusy, hostTx;
  logic syncMode = 1'b0;
  logic toggle = 1'b0;
  logic asyncChk = 1'b0;
  logic rdPend = 1'b0;
  logic [5:0] hist = 6'h00;
  logic [7:0] expQ[$];
  logic [7:0] rdExp;
  logic [31:0] shiftIn = 32'h0;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  // system clock and an unrelated host link clock
  always #5 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #62.5 linkClk = ~linkClk;
  end

  // pin levels: device drive wins, undriven pin 0 follows the host, pins 1 and 2 wander
  assign pin0In = pinOe[0] ? pinOut[0] : hostTx;
  assign pin1In = pinOe[1] ? pinOut[1] : toggle;
  assign pin2In = pinOe[2] ? pinOut[2] : ~toggle;

  radio_serial_data_port #(.CAL_FULL_CYCLES(50), .CAL_VCO_CYCLES(20), .SETTLE_CYCLES(10)) u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pin0In(pin0In), .pin1In(pin1In), .pin2In(pin2In), .pinOut(pinOut), .pinOe(pinOe),
    .rxBit(rxBit), .rxBitValid(rxBitValid), .txBit(txBit), .txBitValid(txBitValid),
    .synthOn(synthOn), .calBusy(calBusy));

  host_serial_model u_host (.linkClk(linkClk), .syncMode(syncMode), .bitClk(pinOut[2]),
    .txData(hostTx));

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask : rd

  // counts calibration-busy cycles following a command
  task automatic cal_len(input int e);
    n = 0;
    repeat (300) begin
      #1;
      if (calBusy === 1'b1) n++;
      @(posedge ref_clk);
    end
    `CHK(n, e)
  endtask : cal_len

  task automatic next_bit();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (txBitValid !== 1'b1 && k < 2000);
  endtask : next_bit

  // cycles up to the next rising bit clock
  task automatic clk_rise();
    int k;
    k = 0;
    while (pinOut[2] !== 1'b0 && k < 500) begin
      @(posedge ref_clk);
      k++;
    end
    while (pinOut[2] !== 1'b1 && k < 500) begin
      @(posedge ref_clk);
      k++;
    end
    n = k;
  endtask : clk_rise

  // monitor: read answers, async transmit samples, timeout
  always @(posedge ref_clk) begin
    toggle <= ~toggle;
    hist <= {hist[4:0], pin0In};
    rdPend <= regRd;
    cycles++;
    if (rdPend === 1'b1) begin
      rdExp = expQ.pop_front();
      `CHK(regRdata, rdExp)
    end
    if (asyncChk && txBitValid === 1'b1 && (hist === 6'h00 || hist === 6'h3F)) begin
      `CHK(txBit, hist[0])
    end
    if (cycles == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h647B));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    `CHK(pinOe, 3'h7)
    `CHK(pinOut, 3'h0)
    `CHK({synthOn, calBusy}, 2'h0)
    rd(serial_port_pkg::ADDR_CAL3, CAL3_RST);
    rd(serial_port_pkg::ADDR_RATE, 8'hF9);
    rd(8'h10, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(serial_port_pkg::ADDR_CFG, 8'(f));
      rd(serial_port_pkg::ADDR_CFG, 8'(f));
    end
    $display("done: reset and registers");
    wr(serial_port_pkg::ADDR_RATE, 8'h18);
    wr(serial_port_pkg::ADDR_PINSEL, 8'h2D);
    wr(serial_port_pkg::ADDR_PINSEL, 8'h4D);
    wr(serial_port_pkg::ADDR_PINSEL, 8'h8B);
    wr(serial_port_pkg::ADDR_CFG, 8'h0B);
    wr(serial_port_pkg::ADDR_CMD, 8'h02);
    cal_len(50);
    asyncChk <= 1'b1;
    repeat (1000) @(posedge ref_clk);
    `CHK(pinOe[0], 1'b0)
    n = 0;
    repeat (400) begin
      @(posedge ref_clk);
      #1;
      if (txBitValid === 1'b1) n++;
    end
    `CHK(n, 16)
    asyncChk <= 1'b0;
    $display("done: async transmit");
    wr(serial_port_pkg::ADDR_CMD, 8'h04);
    wr(serial_port_pkg::ADDR_CAL3, CAL3_RST & 8'hCF);
    rd(serial_port_pkg::ADDR_CAL3, 8'h89);
    wr(serial_port_pkg::ADDR_CMD, 8'h01);
    cal_len(20);
    repeat (16) begin
      @(posedge ref_clk);
      rxBit <= 1'($urandom);
      rxBitValid <= 1'b1;
      @(posedge ref_clk);
      rxBitValid <= 1'b0;
      repeat (6) @(posedge ref_clk);
      `CHK(pinOut[1], rxBit)
    end
    `CHK(pinOe[1:0], 2'h3)
    wr(serial_port_pkg::ADDR_CMD, 8'h04);
    wr(serial_port_pkg::ADDR_CFG, 8'h03);
    wr(serial_port_pkg::ADDR_CMD, 8'h01);
    cal_len(0);
    rd(serial_port_pkg::ADDR_STAT, 8'h03);
    $display("done: async receive and calibration");
    wr(serial_port_pkg::ADDR_CMD, 8'h04);
    syncMode <= 1'b1;
    wr(serial_port_pkg::ADDR_CFG, 8'h05);
    wr(serial_port_pkg::ADDR_CMD, 8'h02);
    for (int i = 0; i < 32; i++) begin
      next_bit();
      shiftIn = {shiftIn[30:0], txBit};
    end
    `CHK(shiftIn, serial_port_pkg::PRE_SYNC)
    `CHK(pinOe, 3'h6)
    clk_rise();
    clk_rise();
    `CHK(n, 200)
    wr(serial_port_pkg::ADDR_CMD, 8'h04);
    $display("done: sync transmit");
    end_of_test();
  end
endmodule : radio_serial_data_port_tb
